// ---- hdl/idma_defines.vh ----
/*
 * constants of the four-channel interrupt-started dma engine: register
 * byte offsets, field positions, reset values and sequencer state lengths.
 * assumes inclusion by the engine's design file and the bench top.
 */
`ifndef IDMA_DEFINES_VH
`define IDMA_DEFINES_VH

// per-channel register block: channel n at n * stride
`define IDMA_CH_STRIDE 8'h10
`define IDMA_OFS_SRC 4'h0
`define IDMA_OFS_DST 4'h4
`define IDMA_OFS_CNT 4'h8
`define IDMA_OFS_MODE 4'hC
// global registers
`define IDMA_OFS_SOFTREQ 8'h40
`define IDMA_OFS_BURST 8'h44
`define IDMA_OFS_STATUS 8'h48
`define IDMA_CH_AREA_END 8'h40

// mode register fields
`define IDMA_MODE_SIZE_LO 0
`define IDMA_MODE_DSTM_LO 2
`define IDMA_MODE_SRCM_LO 4
`define IDMA_MODE_SRC8 6
`define IDMA_MODE_DST8 7
`define IDMA_MODE_VEC_LO 8
`define IDMA_MODE_VEC_HI 13

// transfer size codes
`define IDMA_SIZE_BYTE 2'h0
`define IDMA_SIZE_WORD 2'h1
`define IDMA_SIZE_LONG 2'h2
// address step codes
`define IDMA_STEP_INC 2'h0
`define IDMA_STEP_DEC 2'h1

// start vector range of the 30 interrupt sources, 0 means none
`define IDMA_VEC_FIRST 6'h0A
`define IDMA_VEC_LAST 6'h27
`define IDMA_NUM_SRC 30

// priority level of a dma request
`define IDMA_DMA_LEVEL 3'h6

// reset values
`define IDMA_RST_WORD 32'h00000000
`define IDMA_RST_CNT 16'h0000
`define IDMA_RST_MODE 14'h0000
`define IDMA_RST_BITS 4'h0

// sequencer phase lengths in clock states, minus one
`define IDMA_FETCH_LAST 2'h2
`define IDMA_ACC_LAST 2'h1
`define IDMA_ACC_SLOW_LAST 2'h3

`endif

// ---- hdl/idma_engine.v ----
/*
 * four-channel interrupt-started dma engine with its ahb-lite register
 * slave, a simple single-access memory master and the source handshake.
 * assumes: one clock, the memory answers with no wait within the read
 * states, and the interrupt controller holds pending flags as levels.
 */
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "idma_defines.vh"

// Notes on behaviour
// - dma requests serviced at level six
// - no acceptance while cpu halted
// - no acceptance when mask level seven
// - accepting clears the source's pending flag
// - one unit moved, counter minus one
// - zero count: end irq, vector cleared
// - nonzero, no burst: stop without irq
// - cleared vector leaves source as interrupt
// - lowest channel number wins
// - only low 24 address bits drive
// - byte/word/long sizes, inc/dec/hold steps
// - 16-bit counter, zero means 65536
// - thirty sources plus software start
// - fetch, read, dummy, write states
// - slow area adds two states
// - writing one starts, zero ignored
// - finished channel's soft bit cleared
// - soft bit reads one until served
// - burst runs until counter empty
// - soft start during irq transfer merges
module idma_engine (
	// clock and reset
	input wire ref_clk,
	input wire rstn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// cpu and interrupt controller
	input wire [29:0] srcPending,
	input wire [2:0] cpuInterruptMaskLevel,
	input wire cpuHalted,
	output reg [29:0] srcPendingClr,
	output reg [3:0] transferEndIrq,
	// memory master
	output reg [23:0] memAddr,
	output reg memRead,
	output reg memWrite,
	output reg [1:0] memSize,
	output reg [31:0] memWdata,
	input wire [31:0] memRdata,
	output reg dmaBusy
);

	// sequencer states, one-hot
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_FETCH = 5'h02;
	localparam [4:0] ST_READ = 5'h04;
	localparam [4:0] ST_DUMMY = 5'h08;
	localparam [4:0] ST_WRITE = 5'h10;

	// channel registers
	reg [31:0] srcAddrQ [0:3];
	reg [31:0] dstAddrQ [0:3];
	reg [15:0] countQ [0:3];
	reg [13:0] modeQ [0:3];
	reg [3:0] softRequestQ; // soft_request_register
	reg [3:0] burstSelectQ; // burst_select_register

	// bus slave capture of the address phase
	reg wrPendQ;
	reg [7:0] wrAddrQ;

	// sequencer
	reg [4:0] stateQ;
	reg [1:0] phCntQ;
	reg [1:0] chQ;
	reg [31:0] dataQ;
	reg fromIrqQ;

	// request detection per channel
	reg [3:0] irqHit;
	reg [5:0] vecIdx [0:3];
	reg [3:0] pend;
	reg [1:0] pick;
	reg anyPend;
	integer i;
	integer j; // loop index of the clocked process, kept apart from i

	// decoded fields of the active channel
	wire [13:0] actMode = modeQ[chQ];
	wire [1:0] actSize = actMode[`IDMA_MODE_SIZE_LO +: 2];
	wire [31:0] actSrc = srcAddrQ[chQ];
	wire [31:0] actDst = dstAddrQ[chQ];
	wire [15:0] cntNext = countQ[chQ] - 16'h0001;
	// step width in bytes for the active size
	wire [31:0] stepBytes = (actSize == `IDMA_SIZE_BYTE) ? 32'h00000001 :
		(actSize == `IDMA_SIZE_WORD) ? 32'h00000002 : 32'h00000004;

	// slow read or write phase length
	wire srcSlow = actMode[`IDMA_MODE_SRC8] |
		(actSrc[0] & (actSize != `IDMA_SIZE_BYTE));
	wire dstSlow = actMode[`IDMA_MODE_DST8] |
		(actDst[0] & (actSize != `IDMA_SIZE_BYTE));

	// address phase qualifier of the slave
	wire busTake = hsel & htrans[1] & hready;
	wire [7:0] rdAddr = haddr[7:0];

	// new address after one unit, by step mode
	function [31:0] stepAddr;
		input [31:0] addr;
		input [1:0] mode;
		input [31:0] step;
		begin
			if (mode == `IDMA_STEP_INC) begin
				stepAddr = addr + step;
			end else if (mode == `IDMA_STEP_DEC) begin
				stepAddr = addr - step;
			end else begin
				stepAddr = addr;
			end
		end
	endfunction

	// request scan: a channel asks when its vector names a pending source
	always @* begin
		irqHit = 4'h0;
		for (i = 0; i < 4; i = i + 1) begin
			vecIdx[i] = modeQ[i][`IDMA_MODE_VEC_HI:`IDMA_MODE_VEC_LO]
				- `IDMA_VEC_FIRST;
			if (modeQ[i][`IDMA_MODE_VEC_HI:`IDMA_MODE_VEC_LO] >=
				`IDMA_VEC_FIRST &&
				modeQ[i][`IDMA_MODE_VEC_HI:`IDMA_MODE_VEC_LO] <=
				`IDMA_VEC_LAST) begin
				irqHit[i] = srcPending[vecIdx[i][4:0]];
			end
		end
		pend = irqHit | softRequestQ;
		anyPend = |pend;
		if (pend[0]) begin
			pick = 2'h0;
		end else if (pend[1]) begin
			pick = 2'h1;
		end else if (pend[2]) begin
			pick = 2'h2;
		end else begin
			pick = 2'h3;
		end
	end

	// readback of a register, taken at the address phase
	reg [31:0] rdMux;
	always @* begin
		rdMux = 32'h00000000;
		if (rdAddr < `IDMA_CH_AREA_END) begin
			case (rdAddr[3:0])
				`IDMA_OFS_SRC: rdMux = srcAddrQ[rdAddr[5:4]];
				`IDMA_OFS_DST: rdMux = dstAddrQ[rdAddr[5:4]];
				`IDMA_OFS_CNT: rdMux = {16'h0000, countQ[rdAddr[5:4]]};
				`IDMA_OFS_MODE: rdMux = {18'h00000, modeQ[rdAddr[5:4]]};
				default: rdMux = 32'h00000000;
			endcase
		end else if (rdAddr == `IDMA_OFS_SOFTREQ) begin
			rdMux = {28'h0000000, softRequestQ};
		end else if (rdAddr == `IDMA_OFS_BURST) begin
			rdMux = {28'h0000000, burstSelectQ};
		end else if (rdAddr == `IDMA_OFS_STATUS) begin
			rdMux = {24'h000000, fromIrqQ, chQ, stateQ};
		end
	end

	// slave response: zero wait, always okay, read data registered
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hrdata <= `IDMA_RST_WORD;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			wrPendQ <= 1'b0;
			wrAddrQ <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wrPendQ <= busTake & hwrite;
			if (busTake) begin
				wrAddrQ <= rdAddr;
				// unmapped addresses read zero
				hrdata <= hwrite ? `IDMA_RST_WORD : rdMux;
			end
		end
	end

	// software register writes and the sequencer, one process because
	// both update the channel registers; a data-phase write wins except
	// on the soft request bits, where a set always beats a clear
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (j = 0; j < 4; j = j + 1) begin
				srcAddrQ[j] <= `IDMA_RST_WORD;
				dstAddrQ[j] <= `IDMA_RST_WORD;
				countQ[j] <= `IDMA_RST_CNT;
				modeQ[j] <= `IDMA_RST_MODE;
			end
			softRequestQ <= `IDMA_RST_BITS;
			burstSelectQ <= `IDMA_RST_BITS;
			stateQ <= ST_IDLE;
			phCntQ <= 2'h0;
			chQ <= 2'h0;
			dataQ <= `IDMA_RST_WORD;
			fromIrqQ <= 1'b0;
			srcPendingClr <= 30'h00000000;
			transferEndIrq <= `IDMA_RST_BITS;
			memAddr <= 24'h000000;
			memRead <= 1'b0;
			memWrite <= 1'b0;
			memSize <= 2'h0;
			memWdata <= `IDMA_RST_WORD;
			dmaBusy <= 1'b0;
		end else begin
			// pulses last one cycle
			srcPendingClr <= 30'h00000000;
			transferEndIrq <= `IDMA_RST_BITS;
			case (stateQ)
				ST_IDLE: begin
					memRead <= 1'b0;
					memWrite <= 1'b0;
					dmaBusy <= 1'b0;
					if (anyPend && !cpuHalted &&
						(`IDMA_DMA_LEVEL >= cpuInterruptMaskLevel)) begin
						chQ <= pick;
						fromIrqQ <= irqHit[pick];
						dmaBusy <= 1'b1;
						stateQ <= ST_FETCH;
						phCntQ <= `IDMA_FETCH_LAST;
						if (irqHit[pick]) begin
							srcPendingClr[vecIdx[pick][4:0]] <= 1'b1;
						end
					end
				end
				ST_FETCH: begin
					// three fetch states, bus left idle
					if (phCntQ == 2'h0) begin
						stateQ <= ST_READ;
						phCntQ <= srcSlow ? `IDMA_ACC_SLOW_LAST :
							`IDMA_ACC_LAST;
						memAddr <= actSrc[23:0];
						memSize <= actSize;
						memRead <= 1'b1;
					end else begin
						phCntQ <= phCntQ - 2'h1;
					end
				end
				ST_READ: begin
					// data is sampled on the last read state
					if (phCntQ == 2'h0) begin
						dataQ <= memRdata;
						memRead <= 1'b0;
						stateQ <= ST_DUMMY;
					end else begin
						phCntQ <= phCntQ - 2'h1;
					end
				end
				ST_DUMMY: begin
					// address stays as in the read; one idle state
					stateQ <= ST_WRITE;
					phCntQ <= dstSlow ? `IDMA_ACC_SLOW_LAST : `IDMA_ACC_LAST;
					memAddr <= actDst[23:0];
					memWdata <= dataQ;
					memWrite <= 1'b1;
				end
				ST_WRITE: begin
					if (phCntQ == 2'h0) begin
						memWrite <= 1'b0;
						// one unit done, count minus one
						srcAddrQ[chQ] <= stepAddr(actSrc,
							actMode[`IDMA_MODE_SRCM_LO +: 2], stepBytes);
						dstAddrQ[chQ] <= stepAddr(actDst,
							actMode[`IDMA_MODE_DSTM_LO +: 2], stepBytes);
						countQ[chQ] <= cntNext;
						// a soft start during irq work merges
						softRequestQ[chQ] <= 1'b0;
						if (cntNext == 16'h0000) begin
							transferEndIrq[chQ] <= 1'b1;
							modeQ[chQ][`IDMA_MODE_VEC_HI:
								`IDMA_MODE_VEC_LO] <= 6'h00;
							stateQ <= ST_IDLE;
						end else if (burstSelectQ[chQ]) begin
							stateQ <= ST_FETCH;
							phCntQ <= `IDMA_FETCH_LAST;
						end else begin
							stateQ <= ST_IDLE;
						end
					end else begin
						phCntQ <= phCntQ - 2'h1;
					end
				end
				default: begin
					stateQ <= ST_IDLE;
				end
			endcase
			// data phase of a bus write
			if (wrPendQ) begin
				if (wrAddrQ < `IDMA_CH_AREA_END) begin
					case (wrAddrQ[3:0])
						`IDMA_OFS_SRC: srcAddrQ[wrAddrQ[5:4]] <= hwdata;
						`IDMA_OFS_DST: dstAddrQ[wrAddrQ[5:4]] <= hwdata;
						`IDMA_OFS_CNT: countQ[wrAddrQ[5:4]] <= hwdata[15:0];
						`IDMA_OFS_MODE: modeQ[wrAddrQ[5:4]] <= hwdata[13:0];
						default: begin
						end
					endcase
				end else if (wrAddrQ == `IDMA_OFS_SOFTREQ) begin
					// ones start, zeros ignored; set beats clear
					for (j = 0; j < 4; j = j + 1) begin
						if (hwdata[j]) begin
							softRequestQ[j] <= 1'b1;
						end
					end
				end else if (wrAddrQ == `IDMA_OFS_BURST) begin
					burstSelectQ <= hwdata[3:0];
				end
			end
		end
	end

endmodule
`default_nettype wire

// ---- tb/idma_engine_checker.sv ----
/*
 * port assertions of the dma engine: acceptance, state lengths, pulses.
 * assumes it is bound onto idma_engine and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none
module idma_engine_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// cpu side
	input wire logic cpuHalted,
	input wire logic [2:0] cpuInterruptMaskLevel,
	input wire logic [29:0] srcPendingClr,
	input wire logic [3:0] transferEndIrq,
	// memory master
	input wire logic memRead,
	input wire logic memWrite,
	input wire logic dmaBusy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// three fetch states come before the read strobe
	sequence s_fetch; !memRead[*3] ##1 memRead; endsequence
	// a strobe stands two states, or four in a slow area
	sequence s_len(x); x[*2] ##1 !x or x[*4] ##1 !x; endsequence
	property p_haltHolds; !dmaBusy && cpuHalted |=> !dmaBusy; endproperty
	property p_maskSeven;
		!dmaBusy && cpuInterruptMaskLevel == 3'h7 |=> !dmaBusy;
	endproperty
	// a clear pulse belongs to one source, only while busy with no read strobe
	property p_clrAccept;
		|srcPendingClr |-> dmaBusy && !memRead && $onehot(srcPendingClr);
	endproperty
	property p_fetch; $rose(dmaBusy) |-> s_fetch; endproperty
	property p_readLen; $rose(memRead) |-> s_len(memRead); endproperty
	property p_writeLen; $rose(memWrite) |-> s_len(memWrite); endproperty
	// one dummy state between the strobes
	property p_dummy; $fell(memRead) |-> !memWrite ##1 memWrite; endproperty
	property p_endIrq;
		|transferEndIrq |-> $fell(memWrite) && $onehot(transferEndIrq);
	endproperty
	a_haltHolds: assert property (p_haltHolds) else $error("start halted");
	a_maskSeven: assert property (p_maskSeven) else $error("start mask7");
	a_clrAccept: assert property (p_clrAccept) else $error("bad clear");
	a_fetch: assert property (p_fetch) else $error("fetch length");
	a_readLen: assert property (p_readLen) else $error("read length");
	a_writeLen: assert property (p_writeLen) else $error("write len");
	a_dummy: assert property (p_dummy) else $error("dummy state");
	a_endIrq: assert property (p_endIrq) else $error("end pulse");
endmodule
bind idma_engine idma_engine_checker i_idma_engine_checker (
	.ref_clk(ref_clk), .rstn(rstn), .cpuHalted(cpuHalted),
	.cpuInterruptMaskLevel(cpuInterruptMaskLevel),
	.srcPendingClr(srcPendingClr), .transferEndIrq(transferEndIrq),
	.memRead(memRead), .memWrite(memWrite), .dmaBusy(dmaBusy));
`default_nettype wire

// ---- tb/idma_far_side.sv ----
/*
 * far side of the engine: interrupt flags and a zero-wait memory.
 * assumes the bench pulses raise for one cycle per source event.
 */
`timescale 1ns/1ns
`default_nettype none
module idma_far_side (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// source events and engine clears
	input wire logic [29:0] raise,
	input wire logic [29:0] srcPendingClr,
	output logic [29:0] srcPending,
	// memory
	input wire logic memRead,
	input wire logic [23:0] memAddr,
	output logic [31:0] memRdata
);
	// flags are levels held until the engine accepts them
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			srcPending <= 30'h0;
			memRdata <= 32'h0;
		end else begin
			srcPending <= (srcPending | raise) & ~srcPendingClr;
			// released lines toggle so a stale word never passes
			memRdata <= memRead ? {8'hC3, memAddr} : ~memRdata;
		end
	end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
 * bench of the dma engine: soft start, masked irq burst, priority.
 * assumes idma_engine, idma_far_side and the checker bind.
 */
`timescale 1ns/1ns
`default_nettype none
`include "idma_defines.vh"
module tb_top;
	logic ref_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic cpuHalted = 1'b0, wrQ = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata, memRdata, memWdata;
	logic [31:0] msk, s, t;
	logic [1:0] htrans = 2'h0, memSize;
	logic [2:0] maskLevel = 3'h0;
	logic [29:0] raise = 30'h0, srcPending, srcPendingClr;
	logic [3:0] transferEndIrq;
	logic [23:0] memAddr;
	logic hreadyout, hresp, memRead, memWrite, dmaBusy;
	logic [57:0] ew;
	logic [57:0] expWr[$]; // dst, size, data of each transfer
	logic [3:0] expIrq[$];
	int errors = 0, numChecks = 0, seed = 20666, k;
	always #50 ref_clk = ~ref_clk;
	idma_engine i_idma_engine (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .srcPending(srcPending),
		.cpuInterruptMaskLevel(maskLevel), .cpuHalted(cpuHalted),
		.srcPendingClr(srcPendingClr), .transferEndIrq(transferEndIrq),
		.memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
		.memSize(memSize), .memWdata(memWdata), .memRdata(memRdata),
		.dmaBusy(dmaBusy));
	idma_far_side i_idma_far_side (.ref_clk(ref_clk), .rstn(rstn),
		.raise(raise), .srcPendingClr(srcPendingClr), .srcPending(srcPending),
		.memRead(memRead), .memAddr(memAddr), .memRdata(memRdata));
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", numChecks, errors);
			if (errors == 0 && numChecks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		begin
			numChecks++;
			if (g !== e) begin
				errors++;
				$display("CHECK FAILED %s exp %h got %h", nm, e, g);
			end
		end
	endtask
	// waits for hready, bounded; a hang closes the run
	task rdy;
		int n;
		begin
			n = 0;
			do begin
				@(posedge ref_clk);
				n++;
			end while (hreadyout !== 1'b1 && n < 50);
			if (n >= 50) begin
				errors++;
				wrap_up;
			end
		end
	endtask
	// one single word transfer: address phase, then data phase
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			hsel <= 1'b1;
			haddr <= {24'h0, a};
			htrans <= 2'h2;
			hwrite <= w;
			rdy;
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
			rdy;
			rd = hrdata;
		end
	endtask
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		begin
			bus(1'b0, a, 32'h0);
			chk(nm, e, rd);
			chk("bus okay", 32'h0, hresp);
		end
	endtask
	task prog(input logic [3:0] c, input logic [31:0] a, input logic [31:0] b,
		input logic [15:0] n, input logic [13:0] m);
		begin
			bus(1'b1, {c, `IDMA_OFS_SRC}, a);
			bus(1'b1, {c, `IDMA_OFS_DST}, b);
			bus(1'b1, {c, `IDMA_OFS_CNT}, {16'h0, n});
			bus(1'b1, {c, `IDMA_OFS_MODE}, {18'h0, m});
		end
	endtask
	// notes n transfers; steps 0 inc, 1 dec, 2 hold
	task plan(input logic [31:0] a, input logic [31:0] b, input int n,
		input logic [1:0] sz, input logic [1:0] sa, input logic [1:0] sb);
		begin
			repeat (n) begin
				expWr.push_back({b[23:0], sz, 8'hC3, a[23:0]});
				a = sa == 2'h0 ? a + (1 << sz) : (sa == 2'h1 ? a - (1 << sz) : a);
				b = sb == 2'h0 ? b + (1 << sz) : (sb == 2'h1 ? b - (1 << sz) : b);
			end
		end
	endtask
	// waits until at most n transfers remain and the engine is idle
	task idle(input int n);
		int c;
		begin
			c = 0;
			while ((expWr.size() > n || dmaBusy !== 1'b0) && c < 3000) begin
				@(posedge ref_clk);
				c++;
			end
			repeat (2) @(posedge ref_clk);
			if (c >= 3000) begin
				errors++;
				wrap_up;
			end
		end
	endtask
	// compares each transfer at its first write state, and end pulses
	always @(posedge ref_clk) begin
		wrQ <= memWrite;
		if (memWrite && !wrQ) begin
			ew = expWr.size() ? expWr.pop_front() : 58'h0;
			msk = 32'hFFFFFFFF >> (6'h20 - (6'h08 << ew[33:32]));
			chk("write addr", ew[57:34], memAddr);
			chk("write size", ew[33:32], memSize);
			chk("write data", ew[31:0] & msk, memWdata & msk);
		end
		if (|transferEndIrq)
			chk("end irq", expIrq.size() ? expIrq.pop_front() : 4'h0, transferEndIrq);
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		s = $random(seed);
		t = $random(seed);
		// word, both addresses increment, two soft starts
		prog(4'h1, s, t, 16'h0002, 14'h0001);
		plan(s, t, 2, 2'h1, 2'h0, 2'h0);
		expIrq.push_back(4'h2);
		cpuHalted <= 1'b1;
		bus(1'b1, `IDMA_OFS_SOFTREQ, 32'h2);
		repeat (10) @(posedge ref_clk);
		rchk("soft pending", `IDMA_OFS_SOFTREQ, 32'h2);
		chk("busy halted", 32'h0, dmaBusy);
		cpuHalted <= 1'b0;
		idle(1);
		rchk("soft done", `IDMA_OFS_SOFTREQ, 32'h0);
		bus(1'b1, `IDMA_OFS_SOFTREQ, 32'h2);
		idle(0);
		rchk("count", {4'h1, `IDMA_OFS_CNT}, 32'h0);
		$display("test soft start done");
		// long, src dec, dst hold in slow area, irq start with burst
		k = {$random(seed)} % 30;
		prog(4'h0, s, t, 16'h0003, {6'h0A + k[5:0], 8'h9A});
		bus(1'b1, `IDMA_OFS_BURST, 32'h1);
		plan(s, t, 3, 2'h2, 2'h1, 2'h2);
		expIrq.push_back(4'h1);
		maskLevel <= 3'h7;
		// source event lasts one cycle; its flag is kept as a level
		raise[k] <= 1'b1;
		@(posedge ref_clk);
		raise <= 30'h0;
		repeat (20) @(posedge ref_clk);
		chk("busy masked", 32'h0, dmaBusy);
		maskLevel <= 3'h6;
		// soft start lands while the irq burst runs
		bus(1'b1, `IDMA_OFS_SOFTREQ, 32'h1);
		idle(0);
		chk("flag cleared", 32'h0, srcPending[k]);
		rchk("vector cleared", `IDMA_OFS_MODE, 32'h9A);
		rchk("burst count", `IDMA_OFS_CNT, 32'h0);
		rchk("soft merged", `IDMA_OFS_SOFTREQ, 32'h0);
		// a cleared vector leaves the source to the cpu
		raise[k] <= 1'b1;
		@(posedge ref_clk);
		raise <= 30'h0;
		repeat (20) @(posedge ref_clk);
		chk("flag kept", 32'h1, srcPending[k]);
		$display("test irq burst done");
		// byte, hold, slow source; two channels wait together
		cpuHalted <= 1'b1;
		bus(1'b1, `IDMA_OFS_BURST, 32'h0);
		prog(4'h3, s, t, 16'h0001, 14'h0068);
		prog(4'h2, t, s, 16'h0001, 14'h0068);
		bus(1'b1, `IDMA_OFS_SOFTREQ, 32'h0);
		bus(1'b1, `IDMA_OFS_SOFTREQ, 32'h8);
		bus(1'b1, `IDMA_OFS_SOFTREQ, 32'h4);
		rchk("soft pair", `IDMA_OFS_SOFTREQ, 32'hC);
		plan(t, s, 1, 2'h0, 2'h2, 2'h2);
		plan(s, t, 1, 2'h0, 2'h2, 2'h2);
		expIrq.push_back(4'h4);
		expIrq.push_back(4'h8);
		cpuHalted <= 1'b0;
		idle(0);
		chk("end irqs left", 32'(expIrq.size()), 32'h0);
		$display("test priority done");
		wrap_up;
	end
endmodule
`default_nettype wire
